// >>> rtl/gpio_pkg.sv
package gpio_pkg;

	// ------------------------------------------------------------
	// pin map: four ports packed into one 26-bit pin vector
	// ------------------------------------------------------------
	localparam int PIN_W = 26;
	localparam int PORTS = 4;
	localparam int PA_BASE = 0;
	localparam int PB_BASE = 8;
	localparam int PC_BASE = 16;
	localparam int PD_BASE = 22;
	localparam int PORT_BASE [PORTS] = '{PA_BASE, PB_BASE, PC_BASE, PD_BASE};
	localparam int PORT_W [PORTS] = '{8, 8, 6, 4};
	localparam int PWM_N = 6;
	localparam int ADC_N = 8;
	localparam int IRQ0_N = 3;
	localparam int WAKE_N = 8;
	localparam int IRQ0_OFS = 4;
	localparam int IRQ1_PIN = PA_BASE + 7;
	localparam int TMR_PIN = PB_BASE + 7;
	localparam int PFD_PIN = PD_BASE;

	// ------------------------------------------------------------
	// register map (byte addresses, one 32-bit word each)
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFF_DATA [PORTS] = '{8'h00, 8'h08, 8'h10, 8'h18};
	localparam logic [ADDR_W-1:0] OFF_DIR [PORTS] = '{8'h04, 8'h0c, 8'h14, 8'h1c};
	localparam logic [ADDR_W-1:0] OFF_WAKE = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_PWM = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_ADC = 8'h2c;
	localparam logic [ADDR_W-1:0] OFF_BITOP = 8'h30;

	// bit operation word: bit index, port, set/clear, data/direction target
	localparam int BOP_BIT_LSB = 0;
	localparam int BOP_BIT_W = 3;
	localparam int BOP_PORT_LSB = 3;
	localparam int BOP_PORT_W = 2;
	localparam int BOP_SET = 5;
	localparam int BOP_DIR = 6;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [PIN_W-1:0] DATA_RST = 26'h3ffffff;
	localparam logic [PIN_W-1:0] DIR_RST = 26'h3ffffff;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic opa_en;
		logic cmp_en;
		logic t1_ext;
		logic t0_ext;
		logic high_side_input_only;
		logic irq1_en;
		logic irq0_en;
	} ctrl_t;
	localparam int CTRL_W = $bits(ctrl_t);

	typedef struct packed {
		logic [PIN_W-1:0] out;
		logic [PIN_W-1:0] oe_n;
		logic [PIN_W-1:0] pull_up;
	} pad_drive_t;

	typedef struct packed {
		logic [PWM_N-1:0] pwm_wave;
		logic pfd_wave;
	} periph_in_t;

	typedef struct packed {
		logic ext_irq0_line_a;
		logic ext_irq0_line_b;
		logic ext_irq0_line_c;
		logic ext_irq1_line;
		logic timer0_ext_input;
		logic timer1_ext_input;
		logic [ADC_N-1:0] adc_analog_sel;
		logic [PWM_N-1:0] pwm_enable;
		logic comparator_sel;
		logic opamp_sel;
	} periph_out_t;

	function automatic int port_of(input int i);
		if (i < PB_BASE) begin
			return 0;
		end else if (i < PC_BASE) begin
			return 1;
		end else if (i < PD_BASE) begin
			return 2;
		end
		return 3;
	endfunction : port_of

	function automatic int bit_of(input int i);
		return i - PORT_BASE[port_of(i)];
	endfunction : bit_of

endpackage : gpio_pkg

// >>> rtl/shared_pin_io_ports.sv
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
module shared_pin_io_ports #(
	parameter logic [gpio_pkg::PIN_W-1:0] PULLUP_OPT = 26'h3ffffff,
	parameter bit IRQ0_ON_PORT_B = 1'b0,
	parameter bit PFD_OPTION = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [gpio_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [gpio_pkg::DATA_W-1:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [gpio_pkg::DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// pads
	input wire logic [gpio_pkg::PIN_W-1:0] pin_in,
	output gpio_pkg::pad_drive_t pad,
	// shared functions
	input wire gpio_pkg::periph_in_t periph_in,
	output gpio_pkg::periph_out_t periph_out,
	// power down
	input wire logic halted,
	output logic wake_request
);
	import gpio_pkg::*;

	localparam int IRQ0_BASE = IRQ0_ON_PORT_B ? PB_BASE + IRQ0_OFS : PA_BASE + IRQ0_OFS;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [PIN_W-1:0] data;
		logic [PIN_W-1:0] dir;
		logic [WAKE_N-1:0] wake_en;
		ctrl_t ctrl;
		logic [PWM_N-1:0] pwm_sel;
		logic [ADC_N-1:0] adc_control;
		logic ack;
		logic [DATA_W-1:0] rdata;
		pad_drive_t pad;
		periph_out_t periph;
	} io_state_t;

	io_state_t st_reg;
	io_state_t st_next;

	logic req;
	logic wr;
	logic bop_hit;
	logic [BOP_PORT_W-1:0] bop_port;
	logic [BOP_BIT_W-1:0] bop_bit;
	logic [DATA_W-1:0] rd;
	logic [PIN_W-1:0] pin_view;
	logic [PIN_W-1:0] alt_en;
	logic [PIN_W-1:0] alt_val;
	logic [PIN_W-1:0] analog;
	logic [PIN_W-1:0] irq0_mask;
	logic [PIN_W-1:0] blocked;
	logic [IRQ0_N-1:0] irq0_lvl;

	// ------------------------------------------------------------
	// bus access and register updates
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
		wr = req & wb_we_i & wb_sel_i[0];
		bop_hit = wr & (wb_adr_i == OFF_BITOP);
		bop_port = wb_dat_i[BOP_PORT_LSB +: BOP_PORT_W];
		bop_bit = wb_dat_i[BOP_BIT_LSB +: BOP_BIT_W];
		rd = '0;
		// input pins are sampled straight from the pads in the read cycle; output pins read back the latch
		pin_view = (st_reg.dir & pin_in) | (~st_reg.dir & st_reg.data);
		st_next.ack = req;

		for (int i = 0; i < PIN_W; i++) begin
			if (req && wb_adr_i == OFF_DATA[port_of(i)]) begin
				rd[bit_of(i)] = pin_view[i];
				if (wr) begin
					st_next.data[i] = wb_dat_i[bit_of(i)];
				end
			end
			if (req && wb_adr_i == OFF_DIR[port_of(i)]) begin
				rd[bit_of(i)] = st_reg.dir[i];
				if (wr) begin
					st_next.dir[i] = wb_dat_i[bit_of(i)];
				end
			end
			// on a data bit operation, input pins of the addressed port get their current level written into the latch too
			if (bop_hit && port_of(i) == int'(bop_port)) begin
				if (wb_dat_i[BOP_DIR]) begin
					if (bit_of(i) == int'(bop_bit)) begin
						st_next.dir[i] = wb_dat_i[BOP_SET];
					end
				end else if (bit_of(i) == int'(bop_bit)) begin
					st_next.data[i] = wb_dat_i[BOP_SET];
				end else begin
					st_next.data[i] = pin_view[i];
				end
			end
		end

		if (req) begin
			unique case (wb_adr_i)
				OFF_WAKE: begin
					rd[WAKE_N-1:0] = st_reg.wake_en;
					if (wr) begin
						st_next.wake_en = wb_dat_i[WAKE_N-1:0];
					end
				end
				OFF_CTRL: begin
					rd[CTRL_W-1:0] = st_reg.ctrl;
					if (wr) begin
						st_next.ctrl = wb_dat_i[CTRL_W-1:0];
					end
				end
				OFF_PWM: begin
					rd[PWM_N-1:0] = st_reg.pwm_sel;
					if (wr) begin
						st_next.pwm_sel = wb_dat_i[PWM_N-1:0];
					end
				end
				OFF_ADC: begin
					rd[ADC_N-1:0] = st_reg.adc_control;
					if (wr) begin
						st_next.adc_control = wb_dat_i[ADC_N-1:0];
					end
				end
				default: begin
				end
			endcase
		end
		st_next.rdata = rd;

		// --------------------------------------------------------
		// pad drive, registered so every pad output is a flop
		// --------------------------------------------------------
		alt_en = '0;
		alt_val = '0;
		alt_en[PC_BASE +: PWM_N] = st_reg.pwm_sel;
		alt_val[PC_BASE +: PWM_N] = periph_in.pwm_wave;
		alt_en[PFD_PIN] = PFD_OPTION;
		alt_val[PFD_PIN] = periph_in.pfd_wave;
		analog = '0;
		analog[PB_BASE +: ADC_N] = st_reg.adc_control;
		irq0_mask = '0;
		irq0_mask[IRQ0_BASE +: IRQ0_N] = '1;
		blocked = irq0_mask & {PIN_W{st_reg.ctrl.high_side_input_only}};

		// alternate waveforms only reach a pin whose direction is output
		st_next.pad.oe_n = st_reg.dir | blocked;
		st_next.pad.out = (alt_en & alt_val) | (~alt_en & st_reg.data);
		st_next.pad.pull_up = st_reg.dir & PULLUP_OPT & ~analog & ~blocked;

		// --------------------------------------------------------
		// shared inputs: irq lines idle high, timer inputs idle low, unless enabled and the pin is an input
		// --------------------------------------------------------
		irq0_lvl = pin_in[IRQ0_BASE +: IRQ0_N] | ~st_reg.dir[IRQ0_BASE +: IRQ0_N]
			| {IRQ0_N{~st_reg.ctrl.irq0_en}};
		st_next.periph.ext_irq0_line_a = irq0_lvl[0];
		st_next.periph.ext_irq0_line_b = irq0_lvl[1];
		st_next.periph.ext_irq0_line_c = irq0_lvl[2];
		st_next.periph.ext_irq1_line = pin_in[IRQ1_PIN] | ~st_reg.dir[IRQ1_PIN]
			| ~st_reg.ctrl.irq1_en;
		st_next.periph.timer0_ext_input = pin_in[TMR_PIN] & st_reg.dir[TMR_PIN]
			& st_reg.ctrl.t0_ext;
		st_next.periph.timer1_ext_input = pin_in[TMR_PIN] & st_reg.dir[TMR_PIN]
			& st_reg.ctrl.t1_ext;
		st_next.periph.adc_analog_sel = st_reg.adc_control;
		st_next.periph.pwm_enable = st_reg.pwm_sel;
		st_next.periph.comparator_sel = st_reg.ctrl.cmp_en;
		st_next.periph.opamp_sel = st_reg.ctrl.opa_en;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '0;
			st_reg.data <= DATA_RST;
			st_reg.dir <= DIR_RST;
			st_reg.pad.out <= DATA_RST;
			st_reg.pad.oe_n <= DIR_RST;
			st_reg.pad.pull_up <= PULLUP_OPT;
			st_reg.periph.ext_irq0_line_a <= 1'b1;
			st_reg.periph.ext_irq0_line_b <= 1'b1;
			st_reg.periph.ext_irq0_line_c <= 1'b1;
			st_reg.periph.ext_irq1_line <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign wb_dat_o = st_reg.rdata;
	assign wb_ack_o = st_reg.ack;
	assign pad = st_reg.pad;
	assign periph_out = st_reg.periph;

	// ------------------------------------------------------------
	// port A wake-up
	// ------------------------------------------------------------
	wake_edge #(
		.WIDTH(WAKE_N)
	) u_wake (
		.clk(clk),
		.reset_n(reset_n),
		.pins(pin_in[PA_BASE +: WAKE_N]),
		.enable(st_reg.wake_en),
		.halted(halted),
		.wake(wake_request)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	property p_input_released;
		st_reg.dir == '1 |=> pad.oe_n == '1;
	endproperty
	a_input_released: assert property (p_input_released) else $error("input pin driven");

	property p_read_latch;
		(req && !wb_we_i && wb_adr_i == OFF_DATA[0] && st_reg.dir[PA_BASE +: 8] == '0)
			|=> wb_ack_o && wb_dat_o[7:0] == $past(st_reg.data[PA_BASE +: 8]);
	endproperty
	a_read_latch: assert property (p_read_latch) else $error("output read not latch");

	property p_latch_hold;
		!(req && wb_we_i) |=> $stable(st_reg.data);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch changed unwritten");

	property p_input_sample;
		(req && !wb_we_i && wb_adr_i == OFF_DATA[1] && st_reg.dir[PB_BASE +: 8] == '1)
			|=> wb_dat_o[7:0] == $past(pin_in[PB_BASE +: 8]);
	endproperty
	a_input_sample: assert property (p_input_sample) else $error("input not sampled");

	property p_reset_ones;
		$rose(reset_n) |-> st_reg.data == DATA_RST && st_reg.dir == DIR_RST;
	endproperty
	a_reset_ones: assert property (p_reset_ones) else $error("reset value wrong");

	property p_high_side_input_only_block;
		st_reg.ctrl.high_side_input_only |=>
			&pad.oe_n[IRQ0_BASE +: IRQ0_N] && !(|pad.pull_up[IRQ0_BASE +: IRQ0_N]);
	endproperty
	a_high_side_input_only_block: assert property (p_high_side_input_only_block) else $error("irq0 pin not input only");

	property p_analog_pull;
		st_reg.adc_control[0] |=> !pad.pull_up[PB_BASE];
	endproperty
	a_analog_pull: assert property (p_analog_pull) else $error("analog pin pulled up");

	property p_pwm_drive;
		(st_reg.pwm_sel[0] && !st_reg.dir[PC_BASE])
			|=> !pad.oe_n[PC_BASE] && pad.out[PC_BASE] == $past(periph_in.pwm_wave[0]);
	endproperty
	a_pwm_drive: assert property (p_pwm_drive) else $error("pwm not on pin");

	property p_bitop_set;
		(wr && wb_adr_i == OFF_BITOP && wb_dat_i[BOP_SET] && !wb_dat_i[BOP_DIR]
			&& wb_dat_i[BOP_SET-1:0] == '0)
			|=> st_reg.data[PA_BASE] && st_reg.data[PA_BASE + 1] == $past(pin_view[PA_BASE + 1]);
	endproperty
	a_bitop_set: assert property (p_bitop_set) else $error("bit set wrong");

	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");

	property p_dir_write;
		(wr && wb_adr_i == OFF_DIR[1]) |=> st_reg.dir[PB_BASE +: 8] == $past(wb_dat_i[7:0]);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("dir write lost");

	property p_output_drive;
		!st_reg.dir[PA_BASE]
			|=> !pad.oe_n[PA_BASE] && pad.out[PA_BASE] == $past(st_reg.data[PA_BASE]);
	endproperty
	a_output_drive: assert property (p_output_drive) else $error("pin not driven");

	property p_pull_output;
		!st_reg.dir[PC_BASE] |=> !pad.pull_up[PC_BASE];
	endproperty
	a_pull_output: assert property (p_pull_output) else $error("output pulled up");

	property p_pull_input;
		st_reg.dir[PD_BASE + 1] |=> pad.pull_up[PD_BASE + 1] == PULLUP_OPT[PD_BASE + 1];
	endproperty
	a_pull_input: assert property (p_pull_input) else $error("pull-up option lost");

	property p_pfd_drive;
		(PFD_OPTION && !st_reg.dir[PFD_PIN])
			|=> !pad.oe_n[PFD_PIN] && pad.out[PFD_PIN] == $past(periph_in.pfd_wave);
	endproperty
	a_pfd_drive: assert property (p_pfd_drive) else $error("divider not on pin");

	property p_irq1_follow;
		(st_reg.ctrl.irq1_en && st_reg.dir[IRQ1_PIN])
			|=> periph_out.ext_irq1_line == $past(pin_in[IRQ1_PIN]);
	endproperty
	a_irq1_follow: assert property (p_irq1_follow) else $error("irq1 not pin level");

	property p_irq0_follow;
		(st_reg.ctrl.irq0_en && st_reg.dir[IRQ0_BASE])
			|=> periph_out.ext_irq0_line_a == $past(pin_in[IRQ0_BASE]);
	endproperty
	a_irq0_follow: assert property (p_irq0_follow) else $error("irq0 not pin level");

	property p_timer_gate;
		!st_reg.dir[TMR_PIN]
			|=> !periph_out.timer0_ext_input && !periph_out.timer1_ext_input;
	endproperty
	a_timer_gate: assert property (p_timer_gate) else $error("timer fed by output");

	property p_select_flags;
		1'b1 |=> periph_out.comparator_sel == $past(st_reg.ctrl.cmp_en)
			&& periph_out.opamp_sel == $past(st_reg.ctrl.opa_en);
	endproperty
	a_select_flags: assert property (p_select_flags) else $error("select flag lost");

endmodule : shared_pin_io_ports

// >>> rtl/wake_edge.sv
`timescale 1ns/10ps
module wake_edge #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// pins and selection
	input wire logic [WIDTH-1:0] pins,
	input wire logic [WIDTH-1:0] enable,
	input wire logic halted,
	// request to the power-down logic
	output logic wake
);

	typedef struct packed {
		logic [WIDTH-1:0] sync1;
		logic [WIDTH-1:0] sync2;
		logic [WIDTH-1:0] prev;
		logic wake;
	} wake_state_t;

	wake_state_t st_reg;
	wake_state_t st_next;
	logic [WIDTH-1:0] fall;

	// pins idle high, so reset to ones to avoid a false edge at start
	always_comb begin
		st_next = st_reg;
		st_next.sync1 = pins;
		st_next.sync2 = st_reg.sync1;
		st_next.prev = st_reg.sync2;
		fall = st_reg.prev & ~st_reg.sync2 & enable;
		st_next.wake = halted & (|fall);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '{sync1: '1, sync2: '1, prev: '1, wake: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign wake = st_reg.wake;

	property p_wake_fall;
		@(posedge clk) disable iff (!reset_n)
		(halted && |(st_reg.prev & ~st_reg.sync2 & enable)) |=> wake;
	endproperty
	a_wake_fall: assert property (p_wake_fall) else $error("wake missed");

	property p_wake_cause;
		@(posedge clk) disable iff (!reset_n)
		wake |-> $past(halted) && $past(|(st_reg.prev & ~st_reg.sync2 & enable));
	endproperty
	a_wake_cause: assert property (p_wake_cause) else $error("spurious wake");

endmodule : wake_edge

// >>> testbench/pin_world.sv
`timescale 1ns/10ps
module pin_world (
	// clock
	input wire logic clk,
	// pad side of the block
	input wire gpio_pkg::pad_drive_t pad,
	// external sources
	input wire logic [gpio_pkg::PIN_W-1:0] ext_val,
	input wire logic [gpio_pkg::PIN_W-1:0] ext_en,
	// resolved levels
	output logic [gpio_pkg::PIN_W-1:0] pin_in
);
	import gpio_pkg::*;

	// ------------------------------------------------------------
	// wire resolution
	// ------------------------------------------------------------
	// a floating pin wanders, so nothing may lean on a stale level
	logic wobble = 1'h0;

	always_ff @(posedge clk) begin
		wobble <= ~wobble;
	end

	// the device driver wins over an external source: no contention model
	always_comb begin
		for (int i = 0; i < PIN_W; i++) begin
			if (!pad.oe_n[i]) begin
				pin_in[i] = pad.out[i];
			end else if (ext_en[i]) begin
				pin_in[i] = ext_val[i];
			end else if (pad.pull_up[i]) begin
				pin_in[i] = 1'h1;
			end else begin
				pin_in[i] = wobble ^ i[0];
			end
		end
	end
endmodule : pin_world

// >>> testbench/shared_pin_io_ports_tb_top.sv
`timescale 1ns/10ps
module shared_pin_io_ports_tb_top;
	import gpio_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic wb_cyc = 1'h0;
	logic wb_stb = 1'h0;
	logic wb_we = 1'h0;
	logic [7:0] wb_adr = 8'h0;
	logic [31:0] wb_dat = 32'h0;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack;
	logic [PIN_W-1:0] pin_in;
	logic [PIN_W-1:0] ext_val = 26'h0;
	logic [PIN_W-1:0] ext_en = 26'h0;
	pad_drive_t pad;
	periph_in_t periph_in = '{pwm_wave: 6'h01, pfd_wave: 1'h1};
	periph_out_t periph_out;
	logic halted = 1'h0;
	logic wake_request;
	int n_fail = 0;
	int cmp_count = 0;
	int c;

	always #2.5 clk = ~clk;

	shared_pin_io_ports #(.PFD_OPTION(1'h1)) shared_pin_io_ports_i (
		.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .pin_in(pin_in), .pad(pad),
		.periph_in(periph_in), .periph_out(periph_out), .halted(halted),
		.wake_request(wake_request)
	);

	pin_world pin_world_i (
		.clk(clk), .pad(pad), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in)
	);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic summarize;
		$display("checks %0d failures %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	// waits for ack with no budget of its own; a hang is left to the watchdog
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk);
		wb_cyc <= 1'h1;
		wb_stb <= 1'h1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat <= d;
		wb_sel <= 4'hf;
		do begin
			@(posedge clk);
		end while (wb_ack !== 1'h1);
		q = wb_dat_o;
		wb_cyc <= 1'h0;
		wb_stb <= 1'h0;
		wb_we <= 1'h0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'h1, a, d, q);
	endtask : wr

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'h0, a, 32'h0, q);
		chk(name, e, q);
	endtask : rd_chk

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	task automatic drive(input logic [PIN_W-1:0] v, input logic [PIN_W-1:0] en);
		@(posedge clk);
		ext_val <= v;
		ext_en <= en;
	endtask : drive

	task automatic count_wake(output int n);
		n = 0;
		repeat (8) begin
			@(posedge clk);
			#1;
			if (wake_request === 1'h1) begin
				n++;
			end
		end
	endtask : count_wake

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		#15000;
		n_fail++;
		summarize();
	end

	initial begin
		repeat (3) @(posedge clk);
		reset_n <= 1'h1;
		#1;
		chk("oe_n", 32'h3ffffff, 32'(pad.oe_n));
		chk("out", 32'h3ffffff, 32'(pad.out));
		for (int p = 0; p < PORTS; p++) begin
			rd_chk("data", OFF_DATA[p], (32'h1 << PORT_W[p]) - 32'h1);
			rd_chk("dir", OFF_DIR[p], (32'h1 << PORT_W[p]) - 32'h1);
		end
		rd_chk("unmapped", 8'h40, 32'h0);
		drive(26'h0a500, 26'h0ff00);
		rd_chk("pins b", OFF_DATA[1], 32'ha5);
		drive(26'h03c00, 26'h0ff00);
		rd_chk("pins b", OFF_DATA[1], 32'h3c);
		wr(OFF_ADC, 32'h0f);
		settle();
		chk("pull b", 32'h70, 32'(pad.pull_up[14:8]));
		chk("adc sel", 32'h0f, 32'(periph_out.adc_analog_sel));
		wr(OFF_ADC, 32'h0);
		wr(OFF_BITOP, 32'h4f);
		rd_chk("dir b", OFF_DIR[1], 32'h7f);
		drive(26'h000a0, 26'h000f0);
		wr(OFF_DIR[0], 32'hf0);
		wr(OFF_DATA[0], 32'h06);
		wr(OFF_BITOP, 32'h20);
		wr(OFF_DIR[0], 32'h00);
		settle();
		chk("out a", 32'ha7, 32'(pad.out[7:0]));
		chk("oe_n a", 32'h0, 32'(pad.oe_n[7:0]));
		rd_chk("latch a", OFF_DATA[0], 32'ha7);
		repeat (10) @(posedge clk);
		chk("out a", 32'ha7, 32'(pad.out[7:0]));
		wr(OFF_PWM, 32'h01);
		wr(OFF_DIR[2], 32'h0);
		wr(OFF_DATA[2], 32'h0);
		settle();
		chk("pwm pins", 32'h1, 32'(pad.out[17:16]));
		chk("pwm en", 32'h01, 32'(periph_out.pwm_enable));
		rd_chk("latch c", OFF_DATA[2], 32'h0);
		wr(OFF_DATA[3], 32'h0);
		settle();
		// the released pad still carries the divider wave; only oe_n keeps it off the pin
		chk("pfd off", 32'h3, 32'({pad.oe_n[22], pad.out[22]}));
		wr(OFF_DIR[3], 32'h0e);
		settle();
		chk("pfd on", 32'h1, 32'({pad.oe_n[22], pad.out[22]}));
		wr(OFF_DIR[0], 32'hff);
		wr(OFF_CTRL, 32'h03);
		drive(26'h20, 26'hf0);
		settle();
		chk("irq lines", 32'h4, 32'({periph_out.ext_irq0_line_a, periph_out.ext_irq0_line_b,
			periph_out.ext_irq0_line_c, periph_out.ext_irq1_line}));
		wr(OFF_CTRL, 32'h04);
		wr(OFF_DIR[0], 32'h0);
		drive(26'h0, 26'h0);
		settle();
		chk("hs in", 32'h38, 32'({pad.oe_n[7:4], pad.pull_up[6:4]}));
		wr(OFF_DIR[1], 32'hff);
		wr(OFF_CTRL, 32'h68);
		drive(26'h8000, 26'h8000);
		settle();
		chk("timer", 32'h2, 32'({periph_out.timer0_ext_input,
			periph_out.timer1_ext_input}));
		chk("ana sel", 32'h3, 32'({periph_out.comparator_sel, periph_out.opamp_sel}));
		wr(OFF_CTRL, 32'h0);
		wr(OFF_DIR[0], 32'hff);
		wr(OFF_WAKE, 32'h01);
		drive(26'h3, 26'h3);
		halted <= 1'h1;
		repeat (4) @(posedge clk);
		drive(26'h2, 26'h3);
		count_wake(c);
		chk("wake a0", 32'h1, 32'(c));
		drive(26'h0, 26'h3);
		count_wake(c);
		chk("wake a1", 32'h0, 32'(c));
		drive(26'h3, 26'h3);
		halted <= 1'h0;
		repeat (4) @(posedge clk);
		drive(26'h2, 26'h3);
		count_wake(c);
		chk("wake run", 32'h0, 32'(c));
		summarize();
	end
endmodule : shared_pin_io_ports_tb_top
